// [design/ssf_pkg.sv]
// ssf_pkg: shared constants and types of the supply status/fault block.
// assumes a single 200 MHz clock and a nine-bit status layout everywhere.
package ssf_pkg;

  // ==========================================================================
  // status vector layout, shared by all four status registers
  localparam int unsigned STATUS_W = 9;
  localparam int unsigned BIT_CV = 0;
  localparam int unsigned BIT_CC = 1;
  localparam int unsigned BIT_OR = 2;
  localparam int unsigned BIT_OV = 3;
  localparam int unsigned BIT_OT = 4;
  localparam int unsigned BIT_AC = 5;
  localparam int unsigned BIT_CURRENT_CUTBACK_TRIP = 6;
  localparam int unsigned BIT_ERR = 7;
  localparam int unsigned BIT_RI = 8;

  typedef logic [STATUS_W-1:0] ssf_status_t;

  // ==========================================================================
  // reset values
  localparam ssf_status_t LATCHED_RST = 9'h000;
  localparam ssf_status_t MASK_RST = 9'h000;
  localparam ssf_status_t TRAP_RST = 9'h000;
  localparam ssf_status_t REPLY_RST = 9'h000;
  // all ones: a condition already true at power-up is no transition
  localparam ssf_status_t PREV_RST = 9'h1FF;
  localparam logic OUT_EN_RST = 1'b1;
  localparam logic SRQ_EN_RST = 1'b0;
  localparam logic ERR_RST = 1'b0;

  // ==========================================================================
  // timing: overrange recognition delay is counted in units of 1 us
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned DELAY_UNIT_NS = 1000;
  localparam int unsigned DELAY_UNIT_CYC =
    (DELAY_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================================
  // reply state machine and query kinds
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_REPLY = 2'b10
  } ssf_state_e;

  typedef enum logic [2:0] {
    QRY_PRESENT = 3'b001,
    QRY_LATCHED = 3'b010,
    QRY_TRAP = 3'b100
  } ssf_query_e;

endpackage : ssf_pkg

// [design/ssf_rise_detect.sv]
// ssf_rise_detect: per-bit false-to-true detector for a status vector.
// assumes level_i is synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ssf_rise_detect (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // level in, one-cycle rise out
  input wire logic [ssf_pkg::STATUS_W-1:0] level_i,
  output logic [ssf_pkg::STATUS_W-1:0] rise_o
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [ssf_pkg::STATUS_W-1:0] prev;
  } ssf_rise_s;

  ssf_rise_s st;
  ssf_rise_s next_st;

  // remember last level; edge only, never the level itself
  always_comb begin
    next_st = st;
    next_st.prev = level_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st.prev <= ssf_pkg::PREV_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rise_o = level_i & ~st.prev;

endmodule : ssf_rise_detect
`default_nettype wire

// [design/ssf_delay_filter.sv]
// ssf_delay_filter: qualifies the overrange level after a programmable delay.
// assumes delay_i is stable-ish; it is compared live, in 1 us units.
`timescale 1ns/1ps
`default_nettype none
module ssf_delay_filter #(
  parameter int unsigned DELAY_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // raw level and delay setting
  input wire logic raw_i,
  input wire logic [DELAY_W-1:0] delay_i,
  // qualified level
  output logic qual_o
);

  localparam int unsigned TICK_W = $clog2(ssf_pkg::DELAY_UNIT_CYC);
  localparam logic [TICK_W-1:0] TICK_LAST =
    TICK_W'(ssf_pkg::DELAY_UNIT_CYC - 1);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic [DELAY_W-1:0] run_cnt;
    logic qual;
  } ssf_dly_s;

  ssf_dly_s st;
  ssf_dly_s next_st;
  logic tick;

  // free-running divider: granularity is one unit, traded for one counter
  always_comb begin
    next_st = st;
    tick = (st.tick_cnt == TICK_LAST);
    next_st.tick_cnt = tick ? '0 : st.tick_cnt + 1'b1;
    if (!raw_i) begin
      next_st.run_cnt = '0;
      next_st.qual = 1'b0;
    end else if (st.run_cnt >= delay_i) begin
      next_st.qual = 1'b1;
    end else if (tick) begin
      next_st.run_cnt = st.run_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign qual_o = st.qual;

endmodule : ssf_delay_filter
`default_nettype wire

// [design/ssf_status_regs.sv]
// ssf_status_regs: status, accumulated, trap-enable and trap registers plus
// output inhibit/enable of a programmable supply.
// assumes an upstream command parser that turns text commands into one-cycle
// strobes, and a formatter that turns the binary reply into decimal text.
//
// Operation
// - output-off strobe inhibits the output, leaves other settings alone
// - every command keeps being accepted while the output is inhibited
// - output-on strobe re-enables the inhibited output
// - present-state vector follows the live conditions every cycle
// - all four registers: CV CC OR OV OT AC CURRENT_CUTBACK_TRIP ERR RI, bits 0..8
// - present-state query returns bits weighted by two to bit position
// - error bit stays set from detection until cleared
// - accumulated bits latch any true present bit until next read
// - accumulated read returns latch, then reloads it from present state
// - only trap-enabled bits may set trap bits
// - trap bits set on false-to-true transitions only
// - trap query returns weighted sum of set trap bits
// - trap read clears the returned trap bits after the reply
// - overrange must persist for the recognition delay to reach trap
// - error set on detection, cleared by the error query
// - poll alarm bit is the OR of all trap bits
// - with service requests on, request service as alarm rises
`timescale 1ns/1ps
`default_nettype none
module ssf_status_regs #(
  parameter int unsigned DELAY_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // live conditions from the supply
  input wire logic const_voltage_flag_i,
  input wire logic const_current_flag_i,
  input wire logic overrange_flag_i,
  input wire logic excess_voltage_trip_i,
  input wire logic thermal_trip_i,
  input wire logic line_dropout_flag_i,
  input wire logic current_cutback_trip_i,
  input wire logic remote_inhibit_input_i,
  input wire logic prog_error_detect_i,
  // overrange recognition delay, in 1 us units
  input wire logic [DELAY_W-1:0] or_delay_i,
  // decoded setting commands, one-cycle strobes
  input wire logic output_off_cmd_i,
  input wire logic output_on_cmd_i,
  input wire logic enable_select_cmd_i,
  input wire logic [ssf_pkg::STATUS_W-1:0] enable_select_data_i,
  input wire logic srq_on_cmd_i,
  input wire logic srq_off_cmd_i,
  input wire logic error_query_i,
  // decoded queries, one-cycle strobes
  input wire logic present_state_query_i,
  input wire logic latched_state_query_i,
  input wire logic trap_query_i,
  output logic query_ready_o,
  // reply towards the formatter
  output logic reply_valid_o,
  output logic [ssf_pkg::STATUS_W-1:0] reply_data_o,
  input wire logic reply_ready_i,
  // supply-side and poll outputs
  output logic output_enable_o,
  output logic prog_error_o,
  output logic poll_alarm_bit_o,
  output logic service_request_o
);

  // ==========================================================================
  // parameter check
  if (DELAY_W < 1 || DELAY_W > 32) begin : g_bad_delay_w
    $error("ssf_status_regs: DELAY_W must lie in 1..32");
  end

  // ==========================================================================
  // state of this module
  typedef struct packed {
    ssf_pkg::ssf_state_e fsm;
    ssf_pkg::ssf_query_e qry;
    ssf_pkg::ssf_status_t reply;
    ssf_pkg::ssf_status_t latched;
    ssf_pkg::ssf_status_t mask;
    ssf_pkg::ssf_status_t trap;
    logic err;
    logic out_en;
    logic srq_en;
    logic srq_pulse;
  } ssf_regs_s;

  ssf_regs_s st;
  ssf_regs_s next_st;

  // ==========================================================================
  // helper functions

  // bits of a register that a completed read leaves behind: only what was
  // reported is removed, so an event arriving meanwhile is kept
  function automatic ssf_pkg::ssf_status_t keep_unreported(
    input ssf_pkg::ssf_status_t value,
    input ssf_pkg::ssf_status_t reported
  );
    keep_unreported = value & ~reported;
  endfunction : keep_unreported

  // any bit set
  function automatic logic any_set(input ssf_pkg::ssf_status_t value);
    any_set = |value;
  endfunction : any_set

  // ==========================================================================
  // present-state vector, purely combinational so it is always current
  ssf_pkg::ssf_status_t present;
  ssf_pkg::ssf_status_t trap_src;
  ssf_pkg::ssf_status_t trap_rise;
  logic or_qualified;

  // assemble live conditions in the shared layout
  always_comb begin
    present = '0;
    present[ssf_pkg::BIT_CV] = const_voltage_flag_i;
    present[ssf_pkg::BIT_CC] = const_current_flag_i;
    present[ssf_pkg::BIT_OR] = overrange_flag_i;
    present[ssf_pkg::BIT_OV] = excess_voltage_trip_i;
    present[ssf_pkg::BIT_OT] = thermal_trip_i;
    present[ssf_pkg::BIT_AC] = line_dropout_flag_i;
    present[ssf_pkg::BIT_CURRENT_CUTBACK_TRIP] = current_cutback_trip_i;
    present[ssf_pkg::BIT_ERR] = st.err;
    present[ssf_pkg::BIT_RI] = remote_inhibit_input_i;
  end

  // trap path sees overrange only after the recognition delay
  always_comb begin
    trap_src = present;
    trap_src[ssf_pkg::BIT_OR] = or_qualified;
  end

  // ==========================================================================
  // overrange qualification
  ssf_delay_filter #(
    .DELAY_W(DELAY_W)
  ) u_or_filter (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .raw_i(overrange_flag_i),
    .delay_i(or_delay_i),
    .qual_o(or_qualified)
  );

  // ==========================================================================
  // edge detection for the trap register
  ssf_rise_detect u_trap_edge (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .level_i(trap_src),
    .rise_o(trap_rise)
  );

  // ==========================================================================
  // next-state logic
  // settings commands are handled in every state: the reply machine only
  // gates queries, so programming continues while inhibited or replying
  always_comb begin
    ssf_pkg::ssf_status_t trap_set;
    logic reply_done;
    trap_set = '0;
    reply_done = 1'b0;
    next_st = st;
    next_st.srq_pulse = 1'b0;

    // output inhibit/enable; off wins if both arrive together, the safe way
    if (output_off_cmd_i) begin
      next_st.out_en = 1'b0;
    end else if (output_on_cmd_i) begin
      next_st.out_en = 1'b1;
    end

    // service request enable
    if (srq_off_cmd_i) begin
      next_st.srq_en = 1'b0;
    end else if (srq_on_cmd_i) begin
      next_st.srq_en = 1'b1;
    end

    // trap-enable register takes exactly the listed bits
    if (enable_select_cmd_i) begin
      next_st.mask = enable_select_data_i;
    end

    // error flag: detection beats a simultaneous clear
    if (error_query_i) begin
      next_st.err = 1'b0;
    end
    if (prog_error_detect_i) begin
      next_st.err = 1'b1;
    end

    // reply machine
    case (st.fsm)
      ssf_pkg::ST_IDLE: begin
        if (present_state_query_i) begin
          next_st.qry = ssf_pkg::QRY_PRESENT;
          next_st.reply = present;
          next_st.fsm = ssf_pkg::ST_REPLY;
        end else if (latched_state_query_i) begin
          next_st.qry = ssf_pkg::QRY_LATCHED;
          next_st.reply = st.latched | present;
          next_st.fsm = ssf_pkg::ST_REPLY;
        end else if (trap_query_i) begin
          next_st.qry = ssf_pkg::QRY_TRAP;
          next_st.reply = st.trap;
          next_st.fsm = ssf_pkg::ST_REPLY;
        end
      end
      ssf_pkg::ST_REPLY: begin
        if (reply_ready_i) begin
          reply_done = 1'b1;
          next_st.fsm = ssf_pkg::ST_IDLE;
        end
      end
      default: begin
        next_st.fsm = ssf_pkg::ST_IDLE;
      end
    endcase

    // accumulated latch: any true present bit sticks; after a read it
    // restarts from the present state plus anything not yet reported
    if (reply_done && st.qry == ssf_pkg::QRY_LATCHED) begin
      next_st.latched = present |
        keep_unreported(st.latched, st.reply);
    end else begin
      next_st.latched = st.latched | present;
    end

    // trap register: enabled rising edges set, a finished read clears
    trap_set = trap_rise & st.mask;
    if (reply_done && st.qry == ssf_pkg::QRY_TRAP) begin
      next_st.trap = keep_unreported(st.trap, st.reply) | trap_set;
    end else begin
      next_st.trap = st.trap | trap_set;
    end

    // service request pulse on the rise of the alarm summary
    next_st.srq_pulse = st.srq_en & any_set(next_st.trap) &
      ~any_set(st.trap);
  end

  // ==========================================================================
  // state register
  // power-up leaves output enabled and every latch/enable cleared
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st.fsm <= ssf_pkg::ST_IDLE;
      st.qry <= ssf_pkg::QRY_PRESENT;
      st.reply <= ssf_pkg::REPLY_RST;
      st.latched <= ssf_pkg::LATCHED_RST;
      st.mask <= ssf_pkg::MASK_RST;
      st.trap <= ssf_pkg::TRAP_RST;
      st.err <= ssf_pkg::ERR_RST;
      st.out_en <= ssf_pkg::OUT_EN_RST;
      st.srq_en <= ssf_pkg::SRQ_EN_RST;
      st.srq_pulse <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  // queries are taken only when no reply is outstanding
  assign query_ready_o = (st.fsm == ssf_pkg::ST_IDLE);
  assign reply_valid_o = (st.fsm == ssf_pkg::ST_REPLY);
  // binary value; its decimal rendering is the weighted sum
  assign reply_data_o = st.reply;
  assign output_enable_o = st.out_en;
  assign prog_error_o = st.err;
  // summary alarm: clearing the trap register clears it too
  assign poll_alarm_bit_o = any_set(st.trap);
  assign service_request_o = st.srq_pulse;

endmodule : ssf_status_regs
`default_nettype wire

// [test/ssf_status_regs_assertions.sv]
// port checker of the supply status and trap block
// assumes it is bound onto ssf_status_regs, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module ssf_status_regs_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // command and query strobes
  input wire logic prog_error_detect_i,
  input wire logic output_off_cmd_i,
  input wire logic output_on_cmd_i,
  input wire logic error_query_i,
  input wire logic present_state_query_i,
  input wire logic latched_state_query_i,
  input wire logic trap_query_i,
  input wire logic reply_ready_i,
  // observed outputs
  input wire logic query_ready_o,
  input wire logic reply_valid_o,
  input wire logic [ssf_pkg::STATUS_W-1:0] reply_data_o,
  input wire logic output_enable_o,
  input wire logic prog_error_o,
  input wire logic poll_alarm_bit_o,
  input wire logic service_request_o
);
  // ==========================================================================
  // properties, all on the one clock
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic any_q;
  // several strobes at once still make one reply
  assign any_q = present_state_query_i | latched_state_query_i | trap_query_i;
  property p_off; output_off_cmd_i |=> !output_enable_o; endproperty
  a_off: assert property (p_off) else $error("output not off");
  property p_on; output_on_cmd_i && !output_off_cmd_i |=> output_enable_o;
  endproperty
  a_on: assert property (p_on) else $error("output not back on");
  property p_err_set; prog_error_detect_i |=> prog_error_o; endproperty
  a_err_set: assert property (p_err_set) else $error("error not set");
  property p_err_hold; prog_error_o && !error_query_i |=> prog_error_o;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error lost");
  property p_err_clr; error_query_i && !prog_error_detect_i |=> !prog_error_o;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error kept");
  property p_take; any_q && query_ready_o |=> reply_valid_o && !query_ready_o;
  endproperty
  a_take: assert property (p_take) else $error("query not answered");
  property p_stand;
    reply_valid_o && !reply_ready_i |=> reply_valid_o && $stable(reply_data_o);
  endproperty
  a_stand: assert property (p_stand) else $error("reply not held");
  property p_srq; service_request_o |-> poll_alarm_bit_o; endproperty
  a_srq: assert property (p_srq) else $error("request without alarm");
  property p_rst;
    $fell(srst_i) |-> output_enable_o && !prog_error_o && !poll_alarm_bit_o;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  // main scenarios reached
  c_srq: cover property (service_request_o);
  c_accept: cover property (reply_valid_o && reply_ready_i);
  c_off: cover property (output_off_cmd_i);
endmodule : ssf_status_regs_assertions
bind ssf_status_regs ssf_status_regs_assertions u_ssf_status_regs_assertions (
  .*);
`default_nettype wire

// [test/ssf_reply_sink.sv]
// reply consumer model standing in for the text formatter
// assumes valid_i comes from a register of the block
`timescale 1ns/1ps
`default_nettype none
module ssf_reply_sink (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // reply handshake and stall length
  input wire logic valid_i,
  input wire logic [3:0] stall_i,
  output logic ready_o
);
  logic [3:0] cnt;
  logic tog;
  // counts cycles a reply is held; stall 0 takes it at once
  always_ff @(posedge clk_i) begin
    cnt <= (srst_i || !valid_i || ready_o) ? 4'h0 : cnt + 4'h1;
    // reset keeps ready defined while idle
    tog <= srst_i ? 1'b0 : !tog;
  end
  // outside a reply ready wanders so nothing may lean on it
  assign ready_o = valid_i ? (cnt >= stall_i) : tog;
endmodule : ssf_reply_sink
`default_nettype wire

// [test/tb_top.sv]
// bench: drives strobes and conditions, models the registers, checks replies
// assumes the design, the reply sink and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin \
  $display("[ERR] %s exp=%h got=%h", n, e, s); bad_count++; end end
module tb_top;
  // ==========================================================================
  // stimulus, observed signals and model state
  localparam int OFF = 0, ON = 1, SEL = 2, SON = 3, SOFF = 4, EQ = 5;
  localparam int DET = 6, PRE = 7, LAT = 8, TRP = 9;
  logic clk_i = 1'b0, srst_i = 1'b1;
  logic [9:0] stb = 10'h000;
  logic [8:0] cond = 9'h000, sel_d = 9'h000, r_dat;
  logic [15:0] dly = 16'h0000;
  logic [3:0] stall = 4'h0;
  logic rdy, q_rdy, r_vld, oe, perr, alarm, srq;
  logic [8:0] mask = 9'h000, trap = 9'h000, lat = 9'h000, oldp = 9'h000;
  logic err = 1'b0, srq_en = 1'b0;
  int bad_count = 0, n_tests = 0, srq_n = 0, srq_seen = 0, cyc = 0, i;
  ssf_status_regs u_ssf_status_regs (.clk_i(clk_i), .srst_i(srst_i),
    .const_voltage_flag_i(cond[0]), .const_current_flag_i(cond[1]),
    .overrange_flag_i(cond[2]), .excess_voltage_trip_i(cond[3]),
    .thermal_trip_i(cond[4]), .line_dropout_flag_i(cond[5]),
    .current_cutback_trip_i(cond[6]), .remote_inhibit_input_i(cond[8]),
    .prog_error_detect_i(stb[DET]), .or_delay_i(dly),
    .output_off_cmd_i(stb[OFF]), .output_on_cmd_i(stb[ON]),
    .enable_select_cmd_i(stb[SEL]), .enable_select_data_i(sel_d),
    .srq_on_cmd_i(stb[SON]), .srq_off_cmd_i(stb[SOFF]),
    .error_query_i(stb[EQ]), .present_state_query_i(stb[PRE]),
    .latched_state_query_i(stb[LAT]), .trap_query_i(stb[TRP]),
    .query_ready_o(q_rdy), .reply_valid_o(r_vld), .reply_data_o(r_dat),
    .reply_ready_i(rdy), .output_enable_o(oe), .prog_error_o(perr),
    .poll_alarm_bit_o(alarm), .service_request_o(srq));
  ssf_reply_sink u_ssf_reply_sink (.clk_i(clk_i), .srst_i(srst_i),
    .valid_i(r_vld), .stall_i(stall), .ready_o(rdy));
  // ==========================================================================
  // clock, hang guard and request counter
  initial forever #2.5 clk_i = ~clk_i;
  // sampled mid-cycle, where the registered pulse has settled
  always @(negedge clk_i) begin
    cyc++;
    if (srq === 1'b1) srq_seen++;
    if (cyc == 6000) begin
      bad_count++;
      summarize();
    end
  end
  // ==========================================================================
  // tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // one-cycle strobe; returns settled just after the taking edge
  task automatic pulse(input int b);
    @(posedge clk_i);
    stb[b] <= 1'b1;
    @(posedge clk_i);
    stb <= 10'h000;
    #1;
  endtask : pulse
  // model: enabled rises set traps, any true bit is latched
  task automatic upd();
    logic [8:0] p;
    p = {cond[8], err, cond[6:0]};
    if (trap == 9'h000 && (p & ~oldp & mask) != 9'h000 && srq_en) srq_n++;
    trap |= p & ~oldp & mask;
    lat |= p;
    oldp = p;
  endtask : upd
  // conditions held a few cycles so the short overrange filter settles
  task automatic setc(input logic [8:0] v);
    @(posedge clk_i);
    cond <= v;
    #1;
    upd();
    repeat (4) @(posedge clk_i);
    #1;
  endtask : setc
  task automatic qry(input int b, input logic [8:0] x);
    stall <= 4'($urandom_range(3));
    pulse(b);
    for (i = 0; i < 20 && r_vld !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    `CHK("reply", x, r_dat)
    for (i = 0; i < 20 && r_vld === 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
  endtask : qry
  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'hb9dd_49fe));
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    `CHK("enable", 1'b1, oe)
    `CHK("alarm", 1'b0, alarm)
    qry(TRP, 9'h000);
    qry(LAT, 9'h000);
    $display("test reset finished");
    pulse(OFF);
    `CHK("enable", 1'b0, oe)
    sel_d <= 9'($urandom);
    pulse(SEL);
    mask = sel_d;
    pulse(SON);
    srq_en = 1'b1;
    `CHK("enable", 1'b0, oe)
    pulse(ON);
    `CHK("enable", 1'b1, oe)
    $display("test inhibit finished");
    repeat (6) begin
      setc(9'($urandom) & 9'h17f);
      qry(PRE, oldp);
    end
    qry(TRP, trap);
    trap = 9'h000;
    qry(TRP, trap);
    `CHK("alarm", 1'b0, alarm)
    `CHK("srq", srq_n, srq_seen)
    $display("test present and trap finished");
    setc(9'h010);
    setc(9'h000);
    qry(LAT, lat | oldp);
    lat = oldp;
    qry(LAT, lat);
    $display("test latched finished");
    pulse(DET);
    err = 1'b1;
    upd();
    `CHK("error", 1'b1, perr)
    qry(PRE, oldp);
    pulse(EQ);
    err = 1'b0;
    upd();
    `CHK("error", 1'b0, perr)
    $display("test error finished");
    qry(TRP, trap);
    sel_d <= 9'h1ff;
    pulse(SEL);
    pulse(SOFF);
    // two units: even with divider jitter 60 cycles stay below the delay
    dly <= 16'h0002;
    cond <= 9'h004;
    repeat (60) @(posedge clk_i);
    cond <= 9'h000;
    repeat (10) @(posedge clk_i);
    qry(TRP, 9'h000);
    cond <= 9'h004;
    repeat (600) @(posedge clk_i);
    qry(TRP, 9'h004);
    `CHK("srq", srq_n, srq_seen)
    $display("test overrange finished");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
